// >>> src/art_pkg.sv
// Package for the 16-bit auto-reload timer: offsets, fields, resets, counts.
// Assumes an 8-bit special function register port from the processor core.
package art_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h91;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;
    localparam int BIT_OVERFLOW = 7;
    localparam int BIT_RUN = 2;
    localparam int BIT_CLOCK_SELECT = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam int PRESCALE_DIVIDE = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIVIDE - 1);
endpackage

// >>> src/art_prescaler.sv
// Tick source for the timer: system clock undivided or divided by twelve.
// Assumes one clock domain and a synchronous, active-high reset.
`timescale 1ns/1ns
module art_prescaler (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Control.
    input wire logic run,
    input wire logic undivided,
    // Tick out.
    output logic tick
);
    logic [3:0] div_reg;
    logic [3:0] div_next;
    wire div_wrap = (div_reg == art_pkg::PRESCALE_LAST);

    // The divider is cleared while stopped so a restart begins a full period.
    assign div_next = (!run || div_wrap) ? 4'h0 : div_reg + 4'h1;
    assign tick = run && (undivided || div_wrap);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_next;
        end
    end
endmodule

// >>> src/art_timer.sv
// 16-bit auto-reload timer with its control, reload and count registers.
// Assumes a single-cycle special function register port from the core.
`timescale 1ns/1ns
module art_timer (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Special function register port.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_write,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Interrupt.
    input wire logic interrupt_enable,
    output logic interrupt_request,
    // Overflow event to other blocks.
    output logic overflow_pulse
);
    logic overflow_flag_reg;
    logic run_control_reg;
    logic clock_divide_select_reg;
    logic [7:0] reload_low_reg;
    logic [7:0] reload_high_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic overflow_flag_next;
    logic tick;

    wire wr_control = sfr_write && (sfr_addr == art_pkg::ADDR_CONTROL);
    wire wr_rl_low = sfr_write && (sfr_addr == art_pkg::ADDR_RELOAD_LOW);
    wire wr_rl_high = sfr_write && (sfr_addr == art_pkg::ADDR_RELOAD_HIGH);
    wire wr_cnt_low = sfr_write && (sfr_addr == art_pkg::ADDR_COUNT_LOW);
    wire wr_cnt_high = sfr_write && (sfr_addr == art_pkg::ADDR_COUNT_HIGH);

    art_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(run_control_reg),
        .undivided(clock_divide_select_reg),
        .tick(tick)
    );

    wire roll_over = tick && (count_reg == art_pkg::COUNT_ALL_ONES);
    wire [15:0] reload_value = {reload_high_reg, reload_low_reg};
    wire [15:0] count_step = roll_over ? reload_value : count_reg + 16'h0001;

    // A software write to a count byte wins over the tick in that cycle.
    always_comb begin
        count_next = tick ? count_step : count_reg;
        if (wr_cnt_low) begin
            count_next[7:0] = sfr_wdata;
        end
        if (wr_cnt_high) begin
            count_next[15:8] = sfr_wdata;
        end
    end

    // Hardware or a control write sets the flag; a hardware set in the same cycle beats a clear.
    assign overflow_flag_next = roll_over ? 1'b1 :
        (wr_control ? sfr_wdata[art_pkg::BIT_OVERFLOW] : overflow_flag_reg);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            overflow_flag_reg <= 1'b0;
            run_control_reg <= 1'b0;
            clock_divide_select_reg <= 1'b0;
            reload_low_reg <= art_pkg::RESET_BYTE;
            reload_high_reg <= art_pkg::RESET_BYTE;
            count_reg <= {art_pkg::RESET_BYTE, art_pkg::RESET_BYTE};
            overflow_pulse <= 1'b0;
        end else begin
            overflow_flag_reg <= overflow_flag_next;
            overflow_pulse <= roll_over;
            count_reg <= count_next;
            if (wr_control) begin
                run_control_reg <= sfr_wdata[art_pkg::BIT_RUN];
                clock_divide_select_reg <=
                    sfr_wdata[art_pkg::BIT_CLOCK_SELECT];
            end
            if (wr_rl_low) begin
                reload_low_reg <= sfr_wdata;
            end
            if (wr_rl_high) begin
                reload_high_reg <= sfr_wdata;
            end
        end
    end

    assign interrupt_request = overflow_flag_reg && interrupt_enable;

    // Unused control bits are simply never stored, so they read as zero.
    wire [7:0] control_read = {overflow_flag_reg, 4'h0, run_control_reg,
        clock_divide_select_reg, 1'b0};

    always_comb begin
        case (sfr_addr)
            art_pkg::ADDR_CONTROL: sfr_rdata = control_read;
            art_pkg::ADDR_RELOAD_LOW: sfr_rdata = reload_low_reg;
            art_pkg::ADDR_RELOAD_HIGH: sfr_rdata = reload_high_reg;
            art_pkg::ADDR_COUNT_LOW: sfr_rdata = count_reg[7:0];
            art_pkg::ADDR_COUNT_HIGH: sfr_rdata = count_reg[15:8];
            default: sfr_rdata = 8'h00;
        endcase
    end
endmodule

// >>> verif/art_timer_properties.sv
// Port-level checker for the auto-reload timer.
// Assumes one clock, clk_sys, and a synchronous active-high reset.
`timescale 1ns/1ns
module art_timer_checker (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Register port and events.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_write,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic interrupt_enable,
    input wire logic interrupt_request,
    input wire logic overflow_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic ctl = sfr_addr == 8'h91;
    irq_level_a: assert property (ctl |->
        interrupt_request == (sfr_rdata[7] & interrupt_enable))
        else $error("irq");
    gap_zero_a: assert property (ctl |-> sfr_rdata[6:3] == 4'h0)
        else $error("gap bits");
    bit0_zero_a: assert property (ctl |-> !sfr_rdata[0])
        else $error("bit0");
    flag_on_wrap_a: assert property (
        overflow_pulse && ctl |-> sfr_rdata[7]) else $error("flag on wrap");
    flag_held_a: assert property (
        ctl && sfr_rdata[7] && !sfr_write ##1 ctl |-> sfr_rdata[7])
        else $error("flag lost");
    ctl_write_a: assert property (sfr_write && ctl |=> !ctl ||
        sfr_rdata[2:1] == $past(sfr_wdata[2:1])) else $error("control write");
    reload_write_a: assert property (
        sfr_write && sfr_addr == 8'h92 |=>
        sfr_addr != 8'h92 || sfr_rdata == $past(sfr_wdata))
        else $error("reload");
    count_write_a: assert property (
        sfr_write && sfr_addr == 8'h95 |=>
        sfr_addr != 8'h95 || sfr_rdata == $past(sfr_wdata))
        else $error("count");
endmodule
bind art_timer art_timer_checker i_chk (.clk_sys(clk_sys), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .interrupt_enable(interrupt_enable),
    .interrupt_request(interrupt_request), .overflow_pulse(overflow_pulse));

// >>> verif/art_timer_tb.sv
// Self-checking bench for the auto-reload timer.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ns
module art_timer_tb;
    logic clk_sys = 1'b0, reset = 1'b1, sfr_write = 1'b0;
    logic interrupt_enable = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic interrupt_request, overflow_pulse;
    int failures = 0, compares = 0, seed = 18473, n, rl;
    art_timer i_dut (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr),
        .sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .interrupt_enable(interrupt_enable),
        .interrupt_request(interrupt_request), .overflow_pulse(overflow_pulse));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // The strobe is left high so that back-to-back writes never drop and
    // raise it in one time step; only a following rd or an explicit clear
    // lowers it, so a plain clock wait repeats the write.
    task automatic wr(input logic [7:0] a, d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_write <= 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, e);
        sfr_write <= 1'b0;
        sfr_addr <= a;
        #1 chk("rdata", sfr_rdata, e);
        @(posedge clk_sys);
    endtask
    task automatic test_done;
        if (failures == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        for (n = 8'h91; n < 8'h97; n++) rd(8'(n), 8'h00);
        wr(8'h91, 8'hFF);
        rd(8'h91, 8'h86);
        wr(8'h91, 8'h00);
        rd(8'h91, 8'h00);
        repeat (4) begin
            rl = $random(seed);
            wr(8'h92, 8'(rl));
            rd(8'h92, 8'(rl));
        end
        wr(8'h92, 8'hF0);
        wr(8'h93, 8'hFF);
        wr(8'h94, 8'hFD);
        wr(8'h95, 8'hFF);
        wr(8'h91, 8'h06);
        sfr_write <= 1'b0;
        sfr_addr <= 8'h94;
        n = 0;
        #1;
        while (overflow_pulse !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n == 50) failures++;
        if (n == 50) test_done;
        chk("count", sfr_rdata, 8'hF0);
        chk("irq", {7'h00, interrupt_request}, 8'h01);
        @(posedge clk_sys);
        interrupt_enable <= 1'b0;
        rd(8'h91, 8'h86);
        #1 chk("irq", {7'h00, interrupt_request}, 8'h00);
        wr(8'h91, 8'h02);
        wr(8'h94, 8'h55);
        repeat (5) @(posedge clk_sys);
        rd(8'h94, 8'h55);
        rd(8'h91, 8'h02);
        wr(8'h91, 8'h06);
        repeat (3) @(posedge clk_sys);
        rd(8'h94, 8'h58);
        wr(8'h91, 8'h00);
        wr(8'h94, 8'h00);
        wr(8'h91, 8'h04);
        repeat (20) @(posedge clk_sys);
        rd(8'h94, 8'h01);
        // A flag clear landing on the roll-over edge must lose to the set.
        wr(8'h91, 8'h00);
        wr(8'h94, 8'hFF);
        wr(8'h95, 8'hFF);
        wr(8'h91, 8'h06);
        wr(8'h91, 8'h06);
        rd(8'h91, 8'h86);
        test_done;
    end
endmodule
